// >>> ufnps_pkg.sv
package ufnps_pkg;
  // Register byte offsets
  localparam logic [7:0] FRAME_COUNT_OFS = 8'h3c;
  localparam logic [7:0] PERIODIC_THRESHOLD_OFS = 8'h40;
  // Field widths and reset values
  localparam int FIELD_W = 14;
  localparam int COUNT_W = 16;
  localparam logic [FIELD_W-1:0] THRESHOLD_RST = 14'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [FIELD_W-1:0] NOMINAL_FRAME_LENGTH = 14'h2edf;
  localparam logic [FIELD_W-1:0] REMAINING_RST = 14'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [FIELD_W-1:0] REMAINING_ONE = 14'h0001;
  // Start-of-frame flag position in the interrupt status register
  localparam int SOF_FLAG_BIT = 2;
  localparam logic [31:0] SOF_FLAG_MASK = 32'h0000_0001 << SOF_FLAG_BIT;

  // Frame boundary sequence
  typedef enum logic [1:0] {
    UFNPS_IDLE = 2'b00,
    UFNPS_SOF = 2'b01,
    UFNPS_HCCA = 2'b10,
    UFNPS_FLAG = 2'b11
  } ufnps_state_t;

  // Register access request
  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ufnps_reg_req_t;

  // Frame count write into the shared communication area
  typedef struct packed {
    logic valid;
    logic [COUNT_W-1:0] count;
  } ufnps_hcca_wr_t;
endpackage

// >>> ufnps_core.sv
// What this block does
// - Keep a sixteen-bit frame counter register.
// - Count frames when remaining counter reloads.
// - Count wraps from FFFFh to zero.
// - Count once on entering running state.
// - Count, send token, write HCCA, then fetch.
// - Set start-of-frame flag after HCCA write.
// - Provide a 14-bit periodic start threshold.
// - Reset clears the periodic threshold.
// - Periodic lists win once threshold reached.
// - Finish running control/bulk transaction first.
// - Remaining counter decrements, reloads after zero.
// - Nominal frame length is 11,999 bit times.
`timescale 1ns/100ps
`default_nettype none
module ufnps_core (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire ufnps_pkg::ufnps_reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic bit_tick_i,
  input wire logic running_state_i,
  input wire logic [ufnps_pkg::FIELD_W-1:0] frame_length_i,
  output logic [ufnps_pkg::FIELD_W-1:0] remaining_bit_times_o,
  output logic sof_send_o,
  input wire logic sof_sent_i,
  output ufnps_pkg::ufnps_hcca_wr_t hcca_wr_o,
  input wire logic hcca_wr_ready_i,
  output logic [31:0] status_set_o,
  output logic ed_fetch_go_o,
  input wire logic xfer_busy_i,
  output logic periodic_prio_o,
  output logic periodic_go_o
);
  import ufnps_pkg::*;

  // Register state
  logic [COUNT_W-1:0] frame_count_q; // Full counter, low field visible
  logic [COUNT_W-1:0] frame_count_d;
  logic [FIELD_W-1:0] threshold_q; // Periodic start threshold
  logic [FIELD_W-1:0] threshold_d;
  logic [FIELD_W-1:0] remaining_q; // Bit times left in frame
  logic [FIELD_W-1:0] remaining_d;
  logic running_q; // Last running level, for entry edge
  ufnps_state_t state_q;
  ufnps_state_t state_d;
  logic [31:0] rdata_q;
  logic ack_q;

  // Shared increment with natural wrap
  function automatic logic [COUNT_W-1:0] bump(input logic [COUNT_W-1:0] v);
    bump = v + COUNT_ONE;
  endfunction

  // Decode
  wire wr_count = reg_req_i.req && reg_req_i.wr && (reg_req_i.addr == FRAME_COUNT_OFS);
  wire wr_thresh = reg_req_i.req && reg_req_i.wr && (reg_req_i.addr == PERIODIC_THRESHOLD_OFS);
  wire rd_count = reg_req_i.req && !reg_req_i.wr && (reg_req_i.addr == FRAME_COUNT_OFS);
  wire rd_thresh = reg_req_i.req && !reg_req_i.wr && (reg_req_i.addr == PERIODIC_THRESHOLD_OFS);
  // Running entry and frame boundary
  wire run_entry = running_state_i && !running_q;
  wire at_zero = (remaining_q == REMAINING_RST);
  wire boundary = running_state_i && bit_tick_i && at_zero;
  wire count_step = run_entry || boundary;

  // Frame counter next value; hardware step wins over a driver write
  assign frame_count_d = count_step ? bump(frame_count_q)
    : wr_count ? {frame_count_q[COUNT_W-1:FIELD_W], reg_req_i.wdata[FIELD_W-1:0]}
    : frame_count_q;
  // Only the 14-bit field is stored
  assign threshold_d = wr_thresh ? reg_req_i.wdata[FIELD_W-1:0] : threshold_q;

  // Remaining counter: reload on entry or after zero, else count down
  assign remaining_d = (run_entry || boundary) ? frame_length_i
    : (running_state_i && bit_tick_i) ? remaining_q - REMAINING_ONE
    : remaining_q;

  // Boundary sequence: token, HCCA write, then flag and descriptor fetch in the same cycle
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      UFNPS_IDLE:
      begin
        // New frame starts the token
        if (count_step)
          state_d = UFNPS_SOF;
      end
      UFNPS_SOF:
      begin
        // Wait for token sent
        if (sof_sent_i)
          state_d = UFNPS_HCCA;
      end
      UFNPS_HCCA:
      begin
        // Wait for memory to take the count
        if (hcca_wr_ready_i)
          state_d = UFNPS_FLAG;
      end
      UFNPS_FLAG:
      begin
        // One cycle of flag set and fetch start
        state_d = UFNPS_IDLE;
      end
      default:
      begin
        state_d = UFNPS_IDLE;
      end
    endcase
  end

  // Counter and threshold registers
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      frame_count_q <= COUNT_RST;
      threshold_q <= THRESHOLD_RST;
      remaining_q <= REMAINING_RST;
      running_q <= 1'b0;
    end
    else
    begin
      frame_count_q <= frame_count_d;
      threshold_q <= threshold_d;
      remaining_q <= remaining_d;
      running_q <= running_state_i;
    end
  end

  // Sequencer state
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_q <= UFNPS_IDLE;
    else
      state_q <= state_d;
  end

  // Read data, one cycle after the request; unmapped reads zero
  wire [31:0] rd_mux = rd_count ? {{(32-FIELD_W){1'b0}}, frame_count_q[FIELD_W-1:0]}
    : rd_thresh ? {{(32-FIELD_W){1'b0}}, threshold_q}
    : 32'h0000_0000;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rd_mux;
      ack_q <= reg_req_i.req;
    end
  end

  // Outputs
  assign reg_rdata_o = rdata_q;
  assign reg_ack_o = ack_q;
  assign remaining_bit_times_o = remaining_q;
  assign sof_send_o = (state_q == UFNPS_SOF);
  // Count already incremented when the write is offered
  assign hcca_wr_o.valid = (state_q == UFNPS_HCCA);
  assign hcca_wr_o.count = frame_count_q;
  assign status_set_o = (state_q == UFNPS_FLAG) ? SOF_FLAG_MASK : 32'h0000_0000;
  assign ed_fetch_go_o = (state_q == UFNPS_FLAG);
  // A zero threshold means periodic priority only at the very end
  assign periodic_prio_o = running_state_i && (remaining_q <= threshold_q);
  // Busy control/bulk transfer holds off the periodic list
  assign periodic_go_o = periodic_prio_o && !xfer_busy_i;

  // Assertions
  sequence s_hcca_done;
    hcca_wr_o.valid && hcca_wr_ready_i;
  endsequence
  property p_flag_after_hcca;
    @(posedge core_clk_i) disable iff (!arst_n_i)
      s_hcca_done |=> status_set_o[SOF_FLAG_BIT] && ed_fetch_go_o;
  endproperty

  a_count_on_boundary: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    boundary |=> frame_count_q == bump($past(frame_count_q)))
    else $error("frame count did not step at boundary");
  a_count_on_entry: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    run_entry |=> frame_count_q == bump($past(frame_count_q)))
    else $error("frame count did not step on running entry");
  a_count_wraps: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (count_step && (&frame_count_q)) |=> frame_count_q == COUNT_RST)
    else $error("frame count did not wrap");
  a_reload_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    boundary |=> remaining_q == $past(frame_length_i))
    else $error("remaining counter did not reload");
  a_decrement: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (running_q && running_state_i && bit_tick_i && !at_zero)
      |=> remaining_q == $past(remaining_q) - REMAINING_ONE)
    else $error("remaining counter did not decrement");
  a_token_first: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (count_step && state_q == UFNPS_IDLE) |=> sof_send_o && !hcca_wr_o.valid)
    else $error("token not first after frame step");
  a_hcca_value: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    hcca_wr_o.valid |-> hcca_wr_o.count == frame_count_q && !ed_fetch_go_o)
    else $error("bad HCCA write");
  a_flag_set: assert property (p_flag_after_hcca)
    else $error("flag or fetch missing after HCCA write");
  a_thresh_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    wr_thresh |=> threshold_q == $past(reg_req_i.wdata[FIELD_W-1:0]))
    else $error("threshold write lost");
  a_prio_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (periodic_prio_o && xfer_busy_i) |-> !periodic_go_o)
    else $error("periodic list started over busy transfer");
  a_prio_reach: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (running_state_i && remaining_q == threshold_q && !xfer_busy_i) |-> periodic_go_o)
    else $error("periodic not started at threshold");
  // Priority, once reached, lasts until the frame ends unless the threshold moves
  a_prio_rest: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (periodic_prio_o && !at_zero && !wr_thresh) ##1 running_state_i |-> periodic_prio_o)
    else $error("periodic priority lost before frame end");
  a_read_zero_high: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    reg_ack_o |-> reg_rdata_o[31:FIELD_W] == '0)
    else $error("reserved read bits not zero");
  a_nominal_len: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(running_state_i) && frame_length_i == NOMINAL_FRAME_LENGTH
      |=> remaining_q == NOMINAL_FRAME_LENGTH)
    else $error("nominal frame length mismatch");
endmodule
`default_nettype wire

// >>> ufnps_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// Far side of one handshake: token sender or memory write port
module ufnps_mem_model (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic req_i,
  input wire logic [1:0] dly_i,
  output logic ack_o
);
  logic [1:0] wait_q; // Cycles spent on the open request
  // One-cycle answer after dly_i cycles; never twice for one request
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_q <= 2'h0;
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= req_i && !ack_o && (wait_q >= dly_i);
      wait_q <= (req_i && !ack_o && wait_q < dly_i) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// >>> usb_frame_number_periodic_start_test.sv
`timescale 1ns/100ps
`default_nettype none
module usb_frame_number_periodic_start_test;
  import ufnps_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  ufnps_reg_req_t req = '0;
  ufnps_hcca_wr_t hw;
  logic [31:0] rdata, status;
  logic ack, sof_send, sof_sent, hcca_rdy, fetch, prio, go;
  logic tick = 1'b0, run = 1'b0, busy = 1'b0, pend = 1'b0;
  logic [13:0] flen = 14'h0014, rem, base, thr;
  logic [1:0] dly = 2'h0;
  logic [32:0] rq[$]; // Bit 32 set: read data is compared
  logic [32:0] exp_r;
  logic [15:0] hq[$]; // Expected counts written to shared memory
  int fail_count = 0, compares = 0;
  ufnps_core i_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .bit_tick_i(tick), .running_state_i(run),
    .frame_length_i(flen), .remaining_bit_times_o(rem), .sof_send_o(sof_send),
    .sof_sent_i(sof_sent), .hcca_wr_o(hw), .hcca_wr_ready_i(hcca_rdy),
    .status_set_o(status), .ed_fetch_go_o(fetch), .xfer_busy_i(busy),
    .periodic_prio_o(prio), .periodic_go_o(go));
  ufnps_mem_model i_sof (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_i(sof_send),
    .dly_i(dly), .ack_o(sof_sent));
  ufnps_mem_model i_mem (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_i(hw.valid),
    .dly_i(dly), .ack_o(hcca_rdy));
  initial
  begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One register access; e[32] says whether read data matters
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    @(posedge core_clk_i);
    req <= '{1'b1, w, a, d};
    rq.push_back(e);
    @(posedge core_clk_i);
    req.req <= 1'b0;
  endtask
  // Bounded wait for a value of the frame time left
  task automatic wait_rem(logic [13:0] v);
    int n;
    for (n = 0; n < 3000 && rem !== v; n++)
      @(negedge core_clk_i);
    if (n == 3000)
    begin
      fail_count++;
      results();
    end
  endtask
  // Random bit-time strobes and partner answer delays
  always @(posedge core_clk_i)
  begin
    tick <= ($urandom_range(0, 3) != 0);
    dly <= 2'($urandom_range(0, 3));
  end
  // Result watcher: register answers, memory writes, flag pulses
  always @(negedge core_clk_i)
  begin
    if (ack === 1'b1)
    begin
      exp_r = (rq.size() != 0) ? rq.pop_front() : 33'h0;
      if (exp_r[32])
        check("read data", exp_r[31:0], rdata);
    end
    if (sof_sent === 1'b1)
      check("token request", 32'h1, {31'h0, sof_send});
    if (hw.valid === 1'b1 && hcca_rdy === 1'b1)
    begin
      check("hcca count", {16'h0, hq.pop_front()}, {16'h0, hw.count});
      pend = 1'b1;
    end
    if (fetch === 1'b1 || status !== 32'h0)
    begin
      check("sof flag", SOF_FLAG_MASK, status);
      check("fetch after hcca", 32'h1, {31'h0, pend & fetch});
      pend = 1'b0;
    end
  end
  initial
  begin
    void'($urandom(72426));
    repeat (4) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    acc(0, FRAME_COUNT_OFS, 0, {1'b1, 32'h0});
    acc(0, PERIODIC_THRESHOLD_OFS, 0, {1'b1, 32'h0});
    acc(1, PERIODIC_THRESHOLD_OFS, 32'hffff_ffff, 0);
    acc(0, PERIODIC_THRESHOLD_OFS, 0, {1'b1, 32'h3fff});
    acc(1, PERIODIC_THRESHOLD_OFS, 32'h3e67, 0);
    acc(0, PERIODIC_THRESHOLD_OFS, 0, {1'b1, 32'h3e67});
    acc(0, 8'h44, 0, {1'b1, 32'h0});
    $display("test registers done");
    // Start near the top of the field; the count carries into bit 14 only when base is 3ffbh or more
    base = 14'($urandom_range(16'h3ff9, 16'h3fff));
    thr = 14'($urandom_range(3, 10));
    acc(1, FRAME_COUNT_OFS, {18'h0, base}, 0);
    acc(0, FRAME_COUNT_OFS, 0, {1'b1, 18'h0, base});
    acc(1, PERIODIC_THRESHOLD_OFS, {18'h0, thr}, 0);
    for (int i = 1; i <= 4; i++)
      hq.push_back({2'b00, base} + 16'(i));
    @(posedge core_clk_i);
    run <= 1'b1;
    wait_rem(thr + 14'h1);
    check("early priority", 32'h0, {31'h0, prio});
    @(posedge core_clk_i);
    busy <= 1'b1;
    wait_rem(thr);
    check("priority", 32'h1, {31'h0, prio});
    check("wait for transfer", 32'h0, {31'h0, go});
    @(posedge core_clk_i);
    busy <= 1'b0;
    @(negedge core_clk_i);
    check("periodic start", 32'h1, {31'h0, go});
    $display("test periodic threshold done");
    wait_rem(14'h0);
    wait_rem(flen);
    for (int n = 0; n < 3000 && hq.size() != 0; n++)
      @(negedge core_clk_i);
    check("frames left", 32'h0, hq.size());
    acc(0, FRAME_COUNT_OFS, 0, {1'b1, 18'h0, base + 14'h4});
    $display("test frame sequence done");
    @(posedge core_clk_i);
    run <= 1'b0;
    flen <= NOMINAL_FRAME_LENGTH;
    hq.push_back({2'b00, base} + 16'h5);
    repeat (2) @(posedge core_clk_i);
    run <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    check("nominal reload", 32'h1, {31'h0, rem <= flen && rem >= flen - 14'h3});
    repeat (20) @(negedge core_clk_i);
    check("pending", 32'h0, rq.size() + hq.size());
    $display("test nominal frame done");
    // Reset in mid-run must clear a programmed threshold and the count
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    run <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    acc(0, PERIODIC_THRESHOLD_OFS, 0, {1'b1, 32'h0});
    acc(0, FRAME_COUNT_OFS, 0, {1'b1, 32'h0});
    repeat (2) @(negedge core_clk_i);
    check("reads left", 32'h0, rq.size());
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
